// ### bfail_timer.sv
`timescale 1ns/1ps
// How it works
// - Current mode: phase or residual overcurrent starts counting.
// - Current mode: output after full delay over threshold.
// - Current mode: counter clears when current drops.
// - Current-and-trip: counter halted until trip active.
// - Current-and-trip: both persist for delay, output asserts.
// - Current-and-trip: either dropping resets the counter.
// - Current-or-trip: either condition counts toward output.
// - Current-or-trip: reset when both gone or block active.
// - Digital mode: input active through delay trips.
// - Digital mode: optional current and trip qualifiers.
// - Masked time-stamped ON/OFF events for eight sources.
// - Four separately clearable cumulative occurrence counters.
// - Twelve-entry circular record store on ON events.
// - Record holds stamp, event, currents, times, group.
// - Block sampled per cycle gives blocked, drops start.
// - Shared pick-up drives retrip and failure timers.
module bfail_timer #(
  parameter int PROG_CYCLE_CLKS = bfail_pkg::PROG_CYCLE_CLKS
) (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  // AXI4-Lite write
  input  wire logic        s_axi_awvalid_in,
  input  wire logic [7:0]  s_axi_awaddr_in,
  output logic             s_axi_awready_out,
  input  wire logic        s_axi_wvalid_in,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  output logic             s_axi_wready_out,
  output logic             s_axi_bvalid_out,
  output logic [1:0]       s_axi_bresp_out,
  input  wire logic        s_axi_bready_in,
  // AXI4-Lite read
  input  wire logic        s_axi_arvalid_in,
  input  wire logic [7:0]  s_axi_araddr_in,
  output logic             s_axi_arready_out,
  output logic             s_axi_rvalid_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  input  wire logic        s_axi_rready_in,
  // Measurements
  input  wire logic [15:0] phase_max_in,
  input  wire logic [15:0] residual_in,
  input  wire logic [2:0]  setting_group_in,
  input  wire logic [47:0] stamp_ms_in,
  // Pins
  input  wire logic        trip_monitor_in,
  input  wire logic        dig_input_in,
  input  wire logic        block_in,
  // Protection outputs
  output logic             breaker_failure_output_out,
  output logic             retrip_out,
  output logic             start_out,
  output logic             blocked_out,
  output logic             irq_out,
  // Event stream
  output logic             event_valid_out,
  output logic [2:0]       event_code_out,
  output logic             event_on_out,
  output logic [47:0]      event_stamp_out
);

  localparam int DIV_W = $clog2(PROG_CYCLE_CLKS + 1);
  localparam logic [bfail_pkg::DLY_W-1:0] DLY_MAX = '1;

  function automatic logic [2:0] first_bit(input logic [7:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return m;
  endfunction

  // ==========================================================
  // Pin synchronisers and program cycle
  logic [2:0]       pin_meta;
  logic [2:0]       pin_sync;
  logic [DIV_W-1:0] div_cnt;
  logic             tick;
  logic             tick_d;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
      div_cnt  <= '0;
      tick     <= 1'b0;
      tick_d   <= 1'b0;
    end else begin
      pin_meta <= {block_in, dig_input_in, trip_monitor_in};
      pin_sync <= pin_meta;
      tick     <= (div_cnt == DIV_W'(PROG_CYCLE_CLKS - 1));
      div_cnt  <= (div_cnt == DIV_W'(PROG_CYCLE_CLKS - 1)) ? '0 : div_cnt + 1'b1;
      tick_d   <= tick;
    end
  end

  // ==========================================================
  // Registers
  logic [4:0]                    ctrl;
  logic [15:0]                   ph_thr;
  logic [15:0]                   res_thr;
  logic [bfail_pkg::DLY_W-1:0]   retrip_dly;
  logic [bfail_pkg::DLY_W-1:0]   cbf_dly;
  logic [7:0]                    on_mask;
  logic [7:0]                    off_mask;
  logic [7:0]                    int_stat;
  logic [7:0]                    int_mask;
  logic [3:0]                    rec_sel;
  logic [bfail_pkg::CNT_W-1:0]   occ_cnt [bfail_pkg::CNT_N];
  bfail_pkg::bfail_rec_type      rec_mem [bfail_pkg::REC_DEPTH];
  logic [bfail_pkg::REC_DEPTH-1:0] rec_valid;
  logic [3:0]                    rec_ptr;

  // Sampled inputs and timer state
  logic                        trip_s;
  logic                        di_s;
  logic                        blk_s;
  logic                        ph_pk;
  logic                        res_pk;
  logic [bfail_pkg::DLY_W-1:0] bf_count;
  logic [7:0]                  st;
  logic [7:0]                  st_d;
  logic [7:0]                  pend_on;
  logic [7:0]                  pend_off;

  // ==========================================================
  // Pick-up and criterion
  bfail_pkg::bfail_crit_type crit;
  logic                      cur_pk;
  logic                      pickup;
  logic                      run;
  logic                      active;
  logic [bfail_pkg::DLY_W-1:0] count_next;
  logic [bfail_pkg::DLY_W-1:0] retrip_left;
  logic [bfail_pkg::DLY_W-1:0] cbf_left;

  assign crit   = bfail_pkg::bfail_crit_type'(ctrl[bfail_pkg::CTRL_CRIT_LSB +: 2]);
  assign cur_pk = ph_pk | res_pk;

  always_comb begin
    case (crit)
      bfail_pkg::CRIT_CURRENT: begin
        pickup = cur_pk;
        run    = cur_pk;
      end
      bfail_pkg::CRIT_CUR_AND_TRIP: begin
        pickup = cur_pk;
        run    = cur_pk & trip_s;
      end
      bfail_pkg::CRIT_CUR_OR_TRIP: begin
        pickup = cur_pk | trip_s;
        run    = cur_pk | trip_s;
      end
      bfail_pkg::CRIT_DIGITAL: begin
        pickup = di_s & (cur_pk | !ctrl[bfail_pkg::CTRL_DI_CUR])
               & (trip_s | !ctrl[bfail_pkg::CTRL_DI_MON]);
        run    = pickup;
      end
      default: begin
        pickup = 1'b0;
        run    = 1'b0;
      end
    endcase
  end

  assign active      = pickup & run & !blk_s;
  assign count_next  = !active ? '0 : (bf_count == DLY_MAX) ? bf_count : bf_count + 1'b1;
  assign retrip_left = (retrip_dly > bf_count) ? retrip_dly - bf_count : '0;
  assign cbf_left    = (cbf_dly > bf_count) ? cbf_dly - bf_count : '0;

  // ==========================================================
  // Timer, sampled once per program cycle
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {trip_s, di_s, blk_s, ph_pk, res_pk} <= 5'h00;
      bf_count                   <= '0;
      start_out                  <= 1'b0;
      blocked_out                <= 1'b0;
      retrip_out                 <= 1'b0;
      breaker_failure_output_out <= 1'b0;
    end else if (tick) begin
      {blk_s, di_s, trip_s} <= pin_sync;
      ph_pk  <= phase_max_in > ph_thr;
      res_pk <= residual_in > res_thr;
    end else if (tick_d) begin
      bf_count    <= count_next;
      start_out   <= pickup & !blk_s;
      blocked_out <= pickup & blk_s;
      retrip_out  <= active & ctrl[bfail_pkg::CTRL_RETRIP_EN] & (count_next >= retrip_dly);
      breaker_failure_output_out <= active & (count_next >= cbf_dly);
    end
  end

  // ==========================================================
  // Events, records and interrupt
  logic [7:0] on_new;
  logic [7:0] off_new;
  logic       on_any;
  logic       off_any;
  logic [2:0] sel_idx;
  logic [7:0] sel_bit;

  assign st      = {res_pk, ph_pk, di_s, trip_s, blocked_out, breaker_failure_output_out,
                    retrip_out, start_out};
  assign on_new  = st & ~st_d;
  assign off_new = ~st & st_d;
  assign on_any  = |pend_on;
  assign off_any = |pend_off;
  assign sel_idx = on_any ? first_bit(pend_on) : first_bit(pend_off);
  assign sel_bit = 8'h01 << sel_idx;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_d            <= 8'h00;
      pend_on         <= 8'h00;
      pend_off        <= 8'h00;
      event_valid_out <= 1'b0;
      event_code_out  <= 3'h0;
      event_on_out    <= 1'b0;
      event_stamp_out <= 48'h0;
      rec_valid       <= '0;
      rec_ptr         <= 4'h0;
      irq_out         <= 1'b0;
    end else begin
      st_d     <= st;
      pend_on  <= (pend_on & ~(on_any ? sel_bit : 8'h00)) | on_new;
      pend_off <= (pend_off & ~((!on_any && off_any) ? sel_bit : 8'h00)) | (off_new & off_mask);
      event_valid_out <= on_any ? on_mask[sel_idx] : off_any;
      event_code_out  <= sel_idx;
      event_on_out    <= on_any;
      event_stamp_out <= stamp_ms_in;
      irq_out         <= |(int_stat & int_mask);
      if (on_any) begin
        rec_valid[rec_ptr] <= 1'b1;
        rec_ptr <= (rec_ptr == 4'(bfail_pkg::REC_DEPTH - 1)) ? 4'h0 : rec_ptr + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (on_any) begin
      rec_mem[rec_ptr] <= '{stamp: stamp_ms_in, code: sel_idx, phase: phase_max_in,
                            res: residual_in, retrip_left: retrip_left,
                            cbf_left: cbf_left, grp: setting_group_in};
    end
  end

  // ==========================================================
  // Register readback
  bfail_pkg::bfail_rec_type rec_rd;
  logic                     rec_ok;

  assign rec_ok = (rec_sel < 4'(bfail_pkg::REC_DEPTH)) && rec_valid[rec_sel];
  assign rec_rd = rec_ok ? rec_mem[rec_sel] : '0;

  function automatic logic [31:0] reg_read(input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0;
    case (a)
      bfail_pkg::A_CTRL:     d = {27'h0, ctrl};
      bfail_pkg::A_PH_THR:   d = {16'h0, ph_thr};
      bfail_pkg::A_RES_THR:  d = {16'h0, res_thr};
      bfail_pkg::A_RT_DLY:   d = {12'h0, retrip_dly};
      bfail_pkg::A_CBF_DLY:  d = {12'h0, cbf_dly};
      bfail_pkg::A_STATE:    d = {4'h0, bf_count, st};
      bfail_pkg::A_ON_MASK:  d = {24'h0, on_mask};
      bfail_pkg::A_OFF_MASK: d = {24'h0, off_mask};
      bfail_pkg::A_INT_STAT: d = {24'h0, int_stat};
      bfail_pkg::A_INT_MASK: d = {24'h0, int_mask};
      8'h28:                 d = {16'h0, occ_cnt[0]};
      8'h2C:                 d = {16'h0, occ_cnt[1]};
      8'h30:                 d = {16'h0, occ_cnt[2]};
      8'h34:                 d = {16'h0, occ_cnt[3]};
      bfail_pkg::A_REC_SEL:  d = {28'h0, rec_sel};
      bfail_pkg::A_REC_INFO: d = {16'h0, rec_valid, rec_ptr};
      bfail_pkg::A_REC_W0:   d = rec_rd.stamp[31:0];
      bfail_pkg::A_REC_W1:   d = {5'h0, rec_rd.grp, 5'h0, rec_rd.code, rec_rd.stamp[47:32]};
      bfail_pkg::A_REC_W2:   d = {rec_rd.phase, rec_rd.res};
      bfail_pkg::A_REC_W3:   d = {12'h0, rec_rd.retrip_left};
      bfail_pkg::A_REC_W4:   d = {12'h0, rec_rd.cbf_left};
      default:               d = 32'h0;
    endcase
    return d;
  endfunction

  // ==========================================================
  // AXI4-Lite slave
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        aw_have;
  logic        w_have;
  logic        do_write;
  logic        wr_ok;
  logic        rd_ok;
  logic        ar_take;
  logic [31:0] wr_val;
  logic        int_rd_clr;

  assign do_write   = aw_have & w_have & !s_axi_bvalid_out;
  assign wr_val     = merge(reg_read(aw_addr), w_data, w_strb);
  assign wr_ok      = (aw_addr[1:0] == 2'h0) && (aw_addr <= bfail_pkg::A_REC_SEL)
                      && (aw_addr != bfail_pkg::A_STATE);
  assign rd_ok      = (s_axi_araddr_in[1:0] == 2'h0) && (s_axi_araddr_in <= bfail_pkg::A_REC_W4);
  assign ar_take    = s_axi_arvalid_in & s_axi_arready_out;
  assign int_rd_clr = ar_take && (s_axi_araddr_in == bfail_pkg::A_INT_STAT);

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out  <= 1'b1;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= bfail_pkg::RESP_OKAY;
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0;
      s_axi_rresp_out   <= bfail_pkg::RESP_OKAY;
      aw_have <= 1'b0;
      w_have  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        s_axi_awready_out <= 1'b0;
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        s_axi_wready_out <= 1'b0;
        w_have <= 1'b1;
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
      end
      if (do_write) begin
        aw_have          <= 1'b0;
        w_have           <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= wr_ok ? bfail_pkg::RESP_OKAY : bfail_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out  <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out  <= 1'b1;
      end
      if (ar_take) begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out  <= 1'b1;
        s_axi_rdata_out   <= reg_read(s_axi_araddr_in);
        s_axi_rresp_out   <= rd_ok ? bfail_pkg::RESP_OKAY : bfail_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out  <= 1'b0;
        s_axi_arready_out <= 1'b1;
      end
    end
  end

  // Writable registers and read-clear status
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl       <= bfail_pkg::CTRL_RST;
      ph_thr     <= bfail_pkg::PH_THR_RST;
      res_thr    <= bfail_pkg::RES_THR_RST;
      retrip_dly <= bfail_pkg::RETRIP_DLY_RST;
      cbf_dly    <= bfail_pkg::CBF_DLY_RST;
      on_mask    <= bfail_pkg::EV_MASK_RST;
      off_mask   <= bfail_pkg::EV_MASK_RST;
      int_mask   <= bfail_pkg::INT_MASK_RST;
      rec_sel    <= 4'h0;
      int_stat   <= 8'h00;
    end else begin
      int_stat <= (int_stat & ~(int_rd_clr ? 8'hFF : 8'h00)) | on_new;
      if (do_write) begin
        case (aw_addr)
          bfail_pkg::A_CTRL:     ctrl       <= wr_val[4:0];
          bfail_pkg::A_PH_THR:   ph_thr     <= wr_val[15:0];
          bfail_pkg::A_RES_THR:  res_thr    <= wr_val[15:0];
          bfail_pkg::A_RT_DLY:   retrip_dly <= wr_val[19:0];
          bfail_pkg::A_CBF_DLY:  cbf_dly    <= wr_val[19:0];
          bfail_pkg::A_ON_MASK:  on_mask    <= wr_val[7:0];
          bfail_pkg::A_OFF_MASK: off_mask   <= wr_val[7:0];
          bfail_pkg::A_INT_MASK: int_mask   <= wr_val[7:0];
          bfail_pkg::A_REC_SEL:  rec_sel    <= wr_val[3:0];
          default:               rec_sel    <= rec_sel;
        endcase
      end
    end
  end

  // ==========================================================
  // Cumulative counters, cleared by any write to their word
  for (genvar g = 0; g < bfail_pkg::CNT_N; g++) begin : g_cnt
    logic inc;
    logic clr;
    assign inc = on_new[bfail_pkg::CNT_EV_MAP[3*g +: 3]];
    assign clr = do_write && (aw_addr == bfail_pkg::A_CNT_BASE + 8'(4 * g));
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        occ_cnt[g] <= '0;
      end else if (inc) begin
        occ_cnt[g] <= clr ? 16'h0001 : occ_cnt[g] + 16'h0001;
      end else if (clr) begin
        occ_cnt[g] <= '0;
      end
    end
  end

endmodule

// ### bfail_pkg.sv
package bfail_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_HZ          = 20_000_000;
  localparam int PROG_CYCLE_US   = 5000;
  localparam int PROG_CYCLE_CLKS = CLK_HZ / 1_000_000 * PROG_CYCLE_US;
  localparam int STEP_US         = 5000;
  localparam int RETRIP_DEF_US   = 100_000;
  localparam int CBF_DEF_US      = 200_000;

  // ==========================================================
  // Widths
  localparam int DLY_W     = 20;
  localparam int CUR_W     = 16;
  localparam int CNT_W     = 16;
  localparam int STAMP_W   = 48;
  localparam int GRP_W     = 3;
  localparam int EV_N      = 8;
  localparam int CNT_N     = 4;
  localparam int REC_DEPTH = 12;

  // ==========================================================
  // Reset values
  localparam logic [DLY_W-1:0] RETRIP_DLY_RST = DLY_W'(RETRIP_DEF_US / STEP_US);
  localparam logic [DLY_W-1:0] CBF_DLY_RST    = DLY_W'(CBF_DEF_US / STEP_US);
  localparam logic [4:0]       CTRL_RST       = 5'h04;
  localparam logic [CUR_W-1:0] PH_THR_RST     = 16'h0100;
  localparam logic [CUR_W-1:0] RES_THR_RST    = 16'h0100;
  localparam logic [EV_N-1:0]  EV_MASK_RST    = 8'hFF;
  localparam logic [EV_N-1:0]  INT_MASK_RST   = 8'h00;

  // ==========================================================
  // Control fields
  localparam int CTRL_CRIT_LSB  = 0;
  localparam int CTRL_RETRIP_EN = 2;
  localparam int CTRL_DI_CUR    = 3;
  localparam int CTRL_DI_MON    = 4;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] A_CTRL     = 8'h00;
  localparam logic [7:0] A_PH_THR   = 8'h04;
  localparam logic [7:0] A_RES_THR  = 8'h08;
  localparam logic [7:0] A_RT_DLY   = 8'h0C;
  localparam logic [7:0] A_CBF_DLY  = 8'h10;
  localparam logic [7:0] A_STATE    = 8'h14;
  localparam logic [7:0] A_ON_MASK  = 8'h18;
  localparam logic [7:0] A_OFF_MASK = 8'h1C;
  localparam logic [7:0] A_INT_STAT = 8'h20;
  localparam logic [7:0] A_INT_MASK = 8'h24;
  localparam logic [7:0] A_CNT_BASE = 8'h28;
  localparam logic [7:0] A_REC_SEL  = 8'h38;
  localparam logic [7:0] A_REC_INFO = 8'h3C;
  localparam logic [7:0] A_REC_W0   = 8'h40;
  localparam logic [7:0] A_REC_W1   = 8'h44;
  localparam logic [7:0] A_REC_W2   = 8'h48;
  localparam logic [7:0] A_REC_W3   = 8'h4C;
  localparam logic [7:0] A_REC_W4   = 8'h50;

  // ==========================================================
  // Event indices and counter sources
  localparam logic [2:0] EV_START  = 3'h0;
  localparam logic [2:0] EV_RETRIP = 3'h1;
  localparam logic [2:0] EV_CBF    = 3'h2;
  localparam logic [2:0] EV_BLOCK  = 3'h3;
  localparam logic [11:0] CNT_EV_MAP = {EV_BLOCK, EV_START, EV_CBF, EV_RETRIP};

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CRIT_CURRENT,
    CRIT_CUR_AND_TRIP,
    CRIT_CUR_OR_TRIP,
    CRIT_DIGITAL
  } bfail_crit_type;

  typedef struct packed {
    logic [STAMP_W-1:0] stamp;
    logic [2:0]         code;
    logic [CUR_W-1:0]   phase;
    logic [CUR_W-1:0]   res;
    logic [DLY_W-1:0]   retrip_left;
    logic [DLY_W-1:0]   cbf_left;
    logic [GRP_W-1:0]   grp;
  } bfail_rec_type;

endpackage

// ### bfail_upstream_cb.sv
`timescale 1ns/1ps
// ==========================================================
// Upstream feeder breaker trip circuit
module bfail_upstream_cb (
  // Clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rst_n_in,
  // Trip command from the failure timer
  input  wire logic       trip_cmd_in,
  // Trips seen
  output logic [7:0]      trip_count_out
);
  logic last_cmd;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      last_cmd       <= 1'b0;
      trip_count_out <= 8'h00;
    end else begin
      last_cmd <= trip_cmd_in;
      if (trip_cmd_in && !last_cmd) begin
        trip_count_out <= trip_count_out + 8'h01;
      end
    end
  end
endmodule

// ### bfail_timer_sva.sv
`timescale 1ns/1ps
// ==========================================================
// Port checker
module bfail_timer_sva #(
  parameter int PROG_CYCLE_CLKS = bfail_pkg::PROG_CYCLE_CLKS
) (
  // Clock and reset
  input wire logic       sys_clk_in,
  input wire logic       rst_n_in,
  // Watched outputs
  input wire logic       breaker_failure_output_out,
  input wire logic       retrip_out,
  input wire logic       start_out,
  input wire logic       blocked_out,
  input wire logic       event_valid_out,
  input wire logic [2:0] event_code_out,
  input wire logic       event_on_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_bfo_start; $rose(breaker_failure_output_out) |-> start_out; endproperty
  a_bfo_start: assert property (p_bfo_start) else $error("output rose without start");
  property p_rt_start; $rose(retrip_out) |-> start_out; endproperty
  a_rt_start: assert property (p_rt_start) else $error("retrip rose without start");
  property p_excl; !(start_out && blocked_out); endproperty
  a_excl: assert property (p_excl) else $error("start and blocked together");
  property p_paced; $changed(start_out) |=> $stable(start_out) [*8]; endproperty
  a_paced: assert property (p_paced) else $error("start changed between ticks");
  sequence s_ev(logic [2:0] code, logic on);
    event_valid_out && event_code_out == code && event_on_out == on;
  endsequence
  property p_st_on; $rose(start_out) |-> ##[1:16] s_ev(bfail_pkg::EV_START, 1'b1); endproperty
  a_st_on: assert property (p_st_on) else $error("no start on event");
  property p_st_off; $fell(start_out) |-> ##[1:16] s_ev(bfail_pkg::EV_START, 1'b0); endproperty
  a_st_off: assert property (p_st_off) else $error("no start off event");
  property p_bf_on;
    $rose(breaker_failure_output_out) |-> ##[1:16] s_ev(bfail_pkg::EV_CBF, 1'b1);
  endproperty
  a_bf_on: assert property (p_bf_on) else $error("no failure on event");
  property p_bf_off;
    $fell(breaker_failure_output_out) |-> ##[1:16] s_ev(bfail_pkg::EV_CBF, 1'b0);
  endproperty
  a_bf_off: assert property (p_bf_off) else $error("no failure off event");

  c_bfo: cover property ($rose(breaker_failure_output_out));
  c_blk: cover property ($rose(blocked_out));
  c_rt: cover property ($rose(retrip_out));
endmodule

bind bfail_timer bfail_timer_sva #(.PROG_CYCLE_CLKS(PROG_CYCLE_CLKS)) u_bfail_timer_sva (
  .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
  .breaker_failure_output_out(breaker_failure_output_out), .retrip_out(retrip_out),
  .start_out(start_out), .blocked_out(blocked_out), .event_valid_out(event_valid_out),
  .event_code_out(event_code_out), .event_on_out(event_on_out));

// ### bfail_timer_bench.sv
`timescale 1ns/1ps
`define CHK(NM, EXP, GOT) begin comparisons++; if ((GOT) !== (EXP)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %0h seen %0h", NM, EXP, GOT); end end
module bfail_timer_bench;
  // ==========================================================
  // Signals
  localparam int P = 20;
  localparam int D = 3;
  logic clk, rst_n, awv, wv, arv, trip, dig, blk, awr, wr, bv, arr, rv;
  logic bfo, rt, st, bl, irq, evv, evo;
  logic [7:0] awa, ara, tcnt;
  logic [31:0] wd, rd;
  logic [1:0] br, rr;
  logic [15:0] ph, res;
  logic [2:0] grp, evc;
  logic [47:0] stamp, evs;
  int n_mismatch, comparisons, cyc;

  bfail_timer #(.PROG_CYCLE_CLKS(P)) u_bfail_timer (.sys_clk_in(clk), .rst_n_in(rst_n),
    .s_axi_awvalid_in(awv), .s_axi_awaddr_in(awa), .s_axi_awready_out(awr),
    .s_axi_wvalid_in(wv), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF), .s_axi_wready_out(wr),
    .s_axi_bvalid_out(bv), .s_axi_bresp_out(br), .s_axi_bready_in(1'b1),
    .s_axi_arvalid_in(arv), .s_axi_araddr_in(ara), .s_axi_arready_out(arr),
    .s_axi_rvalid_out(rv), .s_axi_rdata_out(rd), .s_axi_rresp_out(rr), .s_axi_rready_in(1'b1),
    .phase_max_in(ph), .residual_in(res), .setting_group_in(grp), .stamp_ms_in(stamp),
    .trip_monitor_in(trip), .dig_input_in(dig), .block_in(blk),
    .breaker_failure_output_out(bfo), .retrip_out(rt), .start_out(st), .blocked_out(bl),
    .irq_out(irq), .event_valid_out(evv), .event_code_out(evc), .event_on_out(evo),
    .event_stamp_out(evs));
  bfail_upstream_cb u_bfail_upstream_cb (.sys_clk_in(clk), .rst_n_in(rst_n),
    .trip_cmd_in(bfo), .trip_count_out(tcnt));

  // ==========================================================
  // Helpers
  function automatic logic exp_pick(input logic [1:0] c, input logic cu, input logic tr,
                                    input logic dg, input logic q, input logic qm);
    case (c)
      2'h0: return cu;
      2'h1: return cu & tr;
      2'h2: return cu | tr;
      default: return dg & (cu | !q) & (tr | !qm);
    endcase
  endfunction
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int t;
    t = 0;
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1;
    do begin
      @(posedge clk); t++;
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (bv !== 1'b1 && t < 50);
    if (t >= 50) n_mismatch++;
    r = br;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int t;
    t = 0;
    ara <= a; arv <= 1'b1;
    do begin
      @(posedge clk); t++;
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1 && t < 50);
    if (t >= 50) n_mismatch++;
    d = rd; r = rr;
  endtask
  task automatic wp(input int n);
    repeat (n * P) @(posedge clk);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ==========================================================
  // Clock, stamp and timeout
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    stamp <= rst_n ? stamp + 48'h1 : 48'h0;
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r, c;
    logic pa, ra, tr, dg, q, qm, p, m;
    int n_cbf;
    rst_n = 0; awv = 0; wv = 0; arv = 0; awa = 0; ara = 0; wd = 0; ph = 0; res = 0;
    trip = 0; dig = 0; blk = 0; n_mismatch = 0; comparisons = 0;
    n_cbf = 0;
    d = $urandom(32'hFF3A51A8);
    grp = 3'($urandom_range(0, 7));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    axr(bfail_pkg::A_CTRL, d, r); `CHK("ctrl", 32'(bfail_pkg::CTRL_RST), d)
    axr(bfail_pkg::A_CBF_DLY, d, r); `CHK("cbf_dly", 32'(bfail_pkg::CBF_DLY_RST), d)
    axr(bfail_pkg::A_RT_DLY, d, r); `CHK("rt_dly", 32'(bfail_pkg::RETRIP_DLY_RST), d)
    axr(bfail_pkg::A_ON_MASK, d, r); `CHK("on_mask", 32'(bfail_pkg::EV_MASK_RST), d)
    axr(8'h54, d, r); `CHK("unmapped", bfail_pkg::RESP_SLVERR, r)
    axw(bfail_pkg::A_STATE, 32'h0, r); `CHK("ro write", bfail_pkg::RESP_SLVERR, r)
    axw(bfail_pkg::A_CBF_DLY, 32'(D), r);
    axw(bfail_pkg::A_RT_DLY, 32'h2, r);
    for (int i = 0; i < 16; i++) begin
      c = i[1:0]; m = i[2]; q = 1'($urandom_range(0, 1)); qm = 1'($urandom_range(0, 1));
      axw(bfail_pkg::A_CTRL, {27'h0, qm, q, 1'b1, c}, r);
      axw(bfail_pkg::A_INT_MASK, {29'h0, m, 2'h0}, r);
      ph <= bfail_pkg::PH_THR_RST; res <= 16'h0000; trip <= 1'b0; dig <= 1'b0;
      wp(2);
      `CHK("idle", 1'b0, bfo)
      pa = 1'($urandom_range(0, 1)); ra = 1'($urandom_range(0, 1));
      tr = 1'($urandom_range(0, 1)); dg = 1'($urandom_range(0, 1));
      ph <= bfail_pkg::PH_THR_RST + {15'h0, pa}; res <= bfail_pkg::RES_THR_RST + {15'h0, ra};
      trip <= tr; dig <= dg;
      p = exp_pick(c, pa | ra, tr, dg, q, qm);
      wp(D - 1);
      `CHK("early", 1'b0, bfo)
      wp(3);
      `CHK("output", p, bfo)
      `CHK("retrip", p, rt)
      `CHK("start", c == 2'h1 ? pa | ra : p, st)
      `CHK("irq", p & m, irq)
      axr(bfail_pkg::A_INT_STAT, d, r); `CHK("int_stat", p, d[2])
      repeat (3) @(posedge clk);
      `CHK("irq clear", 1'b0, irq)
      n_cbf += p;
      trip <= 1'b0;
      wp(2);
      `CHK("trip drop", exp_pick(c, pa | ra, 1'b0, dg, q, qm), bfo)
    end
    axw(bfail_pkg::A_CTRL, 32'h4, r);
    blk <= 1'b1; ph <= bfail_pkg::PH_THR_RST + 16'h1;
    wp(D + 2);
    `CHK("blocked", 1'b1, bl)
    `CHK("blk out", 1'b0, bfo)
    ph <= bfail_pkg::PH_THR_RST;
    wp(2);
    blk <= 1'b0;
    axr(8'h2C, d, r); `CHK("cbf count", 32'(n_cbf), d)
    axr(8'h34, d, r); `CHK("blk count", 32'h1, d)
    axw(8'h2C, 32'h0, r);
    axr(8'h2C, d, r); `CHK("count clear", 32'h0, d)
    axr(bfail_pkg::A_REC_INFO, d, r); `CHK("slots", 12'hFFF, d[15:4])
    `CHK("upstream trips", 8'(n_cbf), tcnt)
    wrap_up();
  end
endmodule
